// ==== verilog/lvic_pkg.sv ====
package lvic_pkg;

    // ================
    // sizes
    // ================
    localparam int NUM_SRC   = 17;
    localparam int NUM_LVL   = 8;
    localparam int VEC_W     = 8;
    localparam int HADDR_W   = 16;

    // ================
    // apb register byte offsets
    // ================
    localparam logic [7:0] OFS_LEVEL_MASK  = 8'h00;
    localparam logic [7:0] OFS_LEVEL_PRIO  = 8'h04;
    localparam logic [7:0] OFS_SYS_MODE    = 8'h08;
    localparam logic [7:0] OFS_LEVEL_REQ   = 8'h0c;
    localparam logic [7:0] OFS_SRC_PEND    = 8'h10;
    localparam logic [7:0] OFS_SRC_EN      = 8'h14;
    localparam logic [7:0] OFS_EVT_STAT    = 8'h18;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h1c;
    localparam logic [7:0] OFS_LAST_VEC    = 8'h20;

    // ================
    // fields and reset values
    // ================
    localparam int SYM_GIE_BIT   = 0;
    localparam int SYM_FAST_BIT  = 1;
    localparam int SYM_FLVL_LSB  = 2;
    localparam int SYM_W         = 5;
    localparam int EVT_W         = 2;
    localparam int EVT_PEND_BIT  = 0;
    localparam int EVT_DISP_BIT  = 1;
    localparam int IPR_ORDER_LSB = 0;
    localparam int IPR_A_BIT     = 3;
    localparam int IPR_B1_BIT    = 4;
    localparam int IPR_B2_BIT    = 5;
    localparam int IPR_C1_BIT    = 6;
    localparam int IPR_C2_BIT    = 7;

    localparam logic [7:0]         RST_LEVEL_MASK = 8'h00;
    localparam logic [7:0]         RST_LEVEL_PRIO = 8'h00;
    localparam logic [SYM_W-1:0]   RST_SYS_MODE   = 5'h00;
    localparam logic [NUM_SRC-1:0] RST_SRC_EN     = 17'h1ffff;

    // ================
    // vectors
    // ================
    localparam logic [HADDR_W-1:0] RESET_VECTOR = 16'h0100;
    localparam logic [VEC_W-1:0]   VEC_BASE     = 8'hd0;
    // sources whose pending bit hardware clears when serviced
    localparam logic [NUM_SRC-1:0] HW_CLR_MASK  = 17'h00241;

    // source index to level: 0-1 l0, 2-5 l1, 6-8 l2, 9 l3, 10-15 l4, 16 l5
    localparam logic [3*NUM_SRC-1:0] SRC_LEVEL = {
        3'h5, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h2,
        3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0
    };

    typedef enum logic [4:0] {
        LVIC_IDLE  = 5'b00001,
        LVIC_PUSH  = 5'b00010,
        LVIC_FHI   = 5'b00100,
        LVIC_FLO   = 5'b01000,
        LVIC_LOAD  = 5'b10000
    } lvic_state_e;

endpackage : lvic_pkg

// ==== verilog/lvic_prio_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface lvic_prio_if;
    logic [7:0] lvl_req;
    logic [7:0] level_priority_reg;
    logic       valid;
    logic [2:0] level;

    modport req (output lvl_req, output level_priority_reg, input valid, input level);
    modport res (input lvl_req, input level_priority_reg, output valid, output level);
endinterface : lvic_prio_if
`default_nettype wire

// ==== verilog/lvic_prio.sv ====
`timescale 1ns/100ps
`default_nettype none
// ================
// level resolver: groups a(0,1) b(2,3,4) c(5,6,7), ordered by ipr
// ================
module lvic_prio (
    lvic_prio_if.res p
);
    logic       a_v;
    logic [2:0] a_l;
    logic       b_v;
    logic [2:0] b_l;
    logic       c_v;
    logic [2:0] c_l;
    logic       sub_b;
    logic [2:0] sub_b_l;
    logic       sub_c;
    logic [2:0] sub_c_l;

    // group a: ipr a bit lets level 1 beat level 0
    assign a_v = p.lvl_req[0] | p.lvl_req[1];
    assign a_l = (p.level_priority_reg[lvic_pkg::IPR_A_BIT] ? p.lvl_req[1] : ~p.lvl_req[0]) ? 3'h1 : 3'h0;

    // subgroups of b and c: second bit orders the pair
    assign sub_b   = p.lvl_req[3] | p.lvl_req[4];
    assign sub_b_l = (p.level_priority_reg[lvic_pkg::IPR_B2_BIT] ? p.lvl_req[4] : ~p.lvl_req[3]) ? 3'h4 : 3'h3;
    assign sub_c   = p.lvl_req[6] | p.lvl_req[7];
    assign sub_c_l = (p.level_priority_reg[lvic_pkg::IPR_C2_BIT] ? p.lvl_req[7] : ~p.lvl_req[6]) ? 3'h7 : 3'h6;

    // first bit decides single level against its subgroup
    assign b_v = p.lvl_req[2] | sub_b;
    assign b_l = (p.level_priority_reg[lvic_pkg::IPR_B1_BIT] ? p.lvl_req[2] : ~sub_b) ? 3'h2 : sub_b_l;
    assign c_v = p.lvl_req[5] | sub_c;
    assign c_l = (p.level_priority_reg[lvic_pkg::IPR_C1_BIT] ? p.lvl_req[5] : ~sub_c) ? 3'h5 : sub_c_l;

    assign p.valid = a_v | b_v | c_v;

    always_comb begin
        p.level = 3'h0;
        unique case (p.level_priority_reg[2:0])
            3'h1: p.level = a_v ? a_l : (c_v ? c_l : b_l);
            3'h2: p.level = b_v ? b_l : (a_v ? a_l : c_l);
            3'h3: p.level = b_v ? b_l : (c_v ? c_l : a_l);
            3'h4: p.level = c_v ? c_l : (a_v ? a_l : b_l);
            3'h5: p.level = c_v ? c_l : (b_v ? b_l : a_l);
            default: p.level = a_v ? a_l : (b_v ? b_l : c_l);
        endcase
    end
endmodule : lvic_prio
`default_nettype wire

// ==== verilog/lvic_ctl.sv ====
// Behaviour
// RULE_01 - eight levels 0..7, each one interrupt request number
// RULE_02 - level numbers are names only; priority comes from the level priority register
// RULE_03 - among several active levels the priority register picks the winner
// RULE_04 - inside one level the lowest vector address wins
// RULE_05 - up to 128 vectors per level possible; seventeen built
// RULE_06 - seventeen sources, each with its own vector address
// RULE_07 - a vector may serve several sources, pins or internal events
// RULE_08 - one-vector and multi-vector levels, with one or several sources
// RULE_09 - pending bits cleared by hardware on service or by software write
// RULE_10 - a granted interrupt disables all others until re-enabled
// RULE_11 - program counter and flags are pushed before the handler runs
// RULE_12 - handler address is vector byte joined with the following byte
// RULE_13 - every peripheral can raise a request
// RULE_14 - reset 100h, timer a d0h/d2h on level 0, others d4h..f0h
// RULE_15 - global enable is system mode bit 0, set and cleared by instructions
// RULE_16 - level mask holds one enable per level
// RULE_17 - groups: a = 0,1; b = 2..4; c = 5..7
// RULE_18 - reset clears system mode bits 1 and 0
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module lvic_ctl (
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // interrupt sources from pins and peripherals
    input  wire logic [lvic_pkg::NUM_SRC-1:0]  src_event,
    // cpu side
    input  wire logic                          global_on_instr,
    input  wire logic                          global_off_instr,
    output logic                               cpu_irq_req,
    output logic      [2:0]                    cpu_irq_level,
    input  wire logic                          cpu_grant,
    output logic                               push_req,
    input  wire logic                          push_done,
    output logic                               vec_rd_en,
    output logic      [lvic_pkg::HADDR_W-1:0]  vec_rd_addr,
    input  wire logic [7:0]                    vec_rd_data,
    output logic      [lvic_pkg::HADDR_W-1:0]  handler_addr,
    output logic                               handler_valid,
    output logic      [lvic_pkg::HADDR_W-1:0]  reset_vector,
    output logic                               irq
);
    localparam int NS = lvic_pkg::NUM_SRC;
    localparam int NL = lvic_pkg::NUM_LVL;

    // ================
    // source synchronisers and edge detection
    // ================
    logic [NS-1:0] sync1_q;
    logic [NS-1:0] sync2_q;
    logic [NS-1:0] sync3_q;
    logic [NS-1:0] src_rise;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= src_event;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // any block may raise a request by a rising edge on its line
    assign src_rise = sync2_q & ~sync3_q; // [RULE_13]

    // ================
    // apb decode
    // ================
    logic        acc;
    logic        wr;
    logic        hit_mask;
    logic        hit_prio;
    logic        hit_sym;
    logic        hit_req;
    logic        hit_pend;
    logic        hit_en;
    logic        hit_stat;
    logic        hit_emask;
    logic        hit_last;
    logic        hit_any;

    assign acc       = psel & penable;
    assign wr        = acc & pwrite;
    assign hit_mask  = paddr == lvic_pkg::OFS_LEVEL_MASK;
    assign hit_prio  = paddr == lvic_pkg::OFS_LEVEL_PRIO;
    assign hit_sym   = paddr == lvic_pkg::OFS_SYS_MODE;
    assign hit_req   = paddr == lvic_pkg::OFS_LEVEL_REQ;
    assign hit_pend  = paddr == lvic_pkg::OFS_SRC_PEND;
    assign hit_en    = paddr == lvic_pkg::OFS_SRC_EN;
    assign hit_stat  = paddr == lvic_pkg::OFS_EVT_STAT;
    assign hit_emask = paddr == lvic_pkg::OFS_EVT_MASK;
    assign hit_last  = paddr == lvic_pkg::OFS_LAST_VEC;
    assign hit_any   = hit_mask | hit_prio | hit_sym | hit_req | hit_pend | hit_en
                     | hit_stat | hit_emask | hit_last;
    assign pready    = 1'b1;
    assign pslverr   = acc & ~hit_any;

    // ================
    // registers
    // ================
    logic [7:0]                   level_mask_reg_q;
    logic [7:0]                   level_priority_reg_q;
    logic [lvic_pkg::SYM_W-1:0]   system_mode_reg_q;
    logic [lvic_pkg::SYM_W-1:0]   system_mode_reg_d;
    logic [NS-1:0]                src_pend_q;
    logic [NS-1:0]                src_pend_d;
    logic [NS-1:0]                src_en_q;
    logic [lvic_pkg::EVT_W-1:0]   evt_stat_q;
    logic [lvic_pkg::EVT_W-1:0]   evt_mask_q;
    logic [lvic_pkg::EVT_W-1:0]   evt_set;
    logic [lvic_pkg::VEC_W-1:0]   last_vec_q;
    logic                         global_irq_enable_bit;

    assign global_irq_enable_bit = system_mode_reg_q[lvic_pkg::SYM_GIE_BIT]; // [RULE_15]

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            level_mask_reg_q     <= lvic_pkg::RST_LEVEL_MASK;
            level_priority_reg_q <= lvic_pkg::RST_LEVEL_PRIO;
            src_en_q             <= lvic_pkg::RST_SRC_EN;
            evt_mask_q           <= '0;
        end else if (wr) begin
            if (hit_mask) level_mask_reg_q <= pwdata[7:0]; // [RULE_16]
            if (hit_prio) level_priority_reg_q <= pwdata[7:0]; // [RULE_02]
            if (hit_en) src_en_q <= pwdata[NS-1:0];
            if (hit_emask) evt_mask_q <= pwdata[lvic_pkg::EVT_W-1:0];
        end
    end

    // ================
    // winner selection
    // ================
    logic [NS-1:0]                src_act;
    logic [NL-1:0]                lvl_req;
    logic [NL-1:0]                lvl_en;
    logic [NS-1:0]                src_in_win;
    logic [NS-1:0]                src_win;
    logic [4:0]                   src_idx;
    logic [lvic_pkg::VEC_W-1:0]   win_vec;
    logic                         cand;
    lvic_prio_if                  pif ();

    assign src_act = src_pend_q & src_en_q;

    // each source belongs to exactly one level, one vector per source
    genvar gl;
    generate
        for (gl = 0; gl < NL; gl++) begin : g_lvl
            logic [NS-1:0] member;
            genvar gs;
            for (gs = 0; gs < NS; gs++) begin : g_src
                assign member[gs] = lvic_pkg::SRC_LEVEL[3*gs +: 3] == 3'(gl); // [RULE_07] [RULE_08]
            end
            assign lvl_req[gl] = |(src_act & member); // [RULE_01]
        end
    endgenerate

    assign lvl_en      = lvl_req & level_mask_reg_q; // [RULE_16]
    assign pif.lvl_req = lvl_en;
    assign pif.level_priority_reg     = level_priority_reg_q; // [RULE_03] [RULE_17]

    lvic_prio u_prio (
        .p (pif.res)
    );

    generate
        for (gl = 0; gl < NS; gl++) begin : g_win
            assign src_in_win[gl] = src_act[gl]
                                  & (lvic_pkg::SRC_LEVEL[3*gl +: 3] == pif.level);
        end
    endgenerate

    // lowest index is lowest vector, so isolate the lowest set bit
    assign src_win = src_in_win & (~src_in_win + 17'h00001); // [RULE_04]

    always_comb begin
        src_idx = 5'h00;
        for (int i = NS - 1; i >= 0; i--) begin
            if (src_win[i]) src_idx = 5'(i);
        end
    end

    // vector addresses d0h upward in steps of two
    assign win_vec      = lvic_pkg::VEC_BASE + {2'h0, src_idx, 1'b0}; // [RULE_06] [RULE_14]
    assign reset_vector = lvic_pkg::RESET_VECTOR; // [RULE_14]

    // ================
    // dispatch sequence
    // ================
    lvic_pkg::lvic_state_e         state_q;
    lvic_pkg::lvic_state_e         state_d;
    logic [lvic_pkg::VEC_W-1:0]    vec_q;
    logic [7:0]                    hi_q;
    logic [lvic_pkg::HADDR_W-1:0]  haddr_q;
    logic                          hvalid_q;
    logic                          take;

    assign cand          = pif.valid & global_irq_enable_bit;
    assign cpu_irq_req   = cand & (state_q == lvic_pkg::LVIC_IDLE);
    assign cpu_irq_level = pif.level;
    assign take          = cpu_irq_req & cpu_grant;
    assign push_req      = state_q == lvic_pkg::LVIC_PUSH; // [RULE_11]
    assign vec_rd_en     = (state_q == lvic_pkg::LVIC_FHI) | (state_q == lvic_pkg::LVIC_FLO);
    // byte at the vector, then the byte after it
    assign vec_rd_addr   = {8'h00, vec_q | {7'h00, state_q == lvic_pkg::LVIC_FLO}}; // [RULE_12]
    assign handler_addr  = haddr_q;
    assign handler_valid = hvalid_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lvic_pkg::LVIC_IDLE: if (take) state_d = lvic_pkg::LVIC_PUSH;
            lvic_pkg::LVIC_PUSH: if (push_done) state_d = lvic_pkg::LVIC_FHI; // [RULE_11]
            lvic_pkg::LVIC_FHI:  state_d = lvic_pkg::LVIC_FLO;
            lvic_pkg::LVIC_FLO:  state_d = lvic_pkg::LVIC_LOAD;
            lvic_pkg::LVIC_LOAD: state_d = lvic_pkg::LVIC_IDLE;
            default:             state_d = lvic_pkg::LVIC_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q  <= lvic_pkg::LVIC_IDLE;
            vec_q    <= '0;
            hi_q     <= '0;
            haddr_q  <= '0;
            hvalid_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            hvalid_q <= state_q == lvic_pkg::LVIC_LOAD;
            if (take) vec_q <= win_vec;
            if (state_q == lvic_pkg::LVIC_FLO) hi_q <= vec_rd_data;
            if (state_q == lvic_pkg::LVIC_LOAD) haddr_q <= {hi_q, vec_rd_data}; // [RULE_12]
        end
    end

    // ================
    // system mode: instructions, grant and direct writes
    // ================
    always_comb begin
        system_mode_reg_d = system_mode_reg_q;
        if (wr && hit_sym) system_mode_reg_d = pwdata[lvic_pkg::SYM_W-1:0];
        if (global_on_instr) system_mode_reg_d[lvic_pkg::SYM_GIE_BIT] = 1'b1; // [RULE_15]
        if (global_off_instr) system_mode_reg_d[lvic_pkg::SYM_GIE_BIT] = 1'b0; // [RULE_15]
        // a grant wins over everything so no second request slips in
        if (take) system_mode_reg_d[lvic_pkg::SYM_GIE_BIT] = 1'b0; // [RULE_10]
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            system_mode_reg_q <= lvic_pkg::RST_SYS_MODE; // [RULE_18]
        end else begin
            system_mode_reg_q <= system_mode_reg_d;
        end
    end

    // ================
    // source pending bits
    // ================
    always_comb begin
        src_pend_d = src_pend_q;
        // software clears by writing a one
        if (wr && hit_pend) src_pend_d = src_pend_d & ~pwdata[NS-1:0]; // [RULE_09]
        // auto-clear only for sources whose service needs no software action
        if (take) src_pend_d = src_pend_d & ~(src_win & lvic_pkg::HW_CLR_MASK); // [RULE_09]
        // a new edge in the clearing cycle is kept
        src_pend_d = src_pend_d | src_rise;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            src_pend_q <= '0;
            last_vec_q <= '0;
        end else begin
            src_pend_q <= src_pend_d;
            if (take) last_vec_q <= win_vec; // [RULE_05]
        end
    end

    // ================
    // event status and interrupt line
    // ================
    assign evt_set = {hvalid_q, |src_rise};

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            evt_stat_q <= '0;
        end else begin
            evt_stat_q <= (evt_stat_q & ~((wr && hit_stat) ? pwdata[lvic_pkg::EVT_W-1:0]
                                                            : 2'h0)) | evt_set;
        end
    end

    assign irq = |(evt_stat_q & evt_mask_q);

    // ================
    // read data
    // ================
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_mask)  rd_mux[7:0] = level_mask_reg_q;
        if (hit_prio)  rd_mux[7:0] = level_priority_reg_q;
        if (hit_sym)   rd_mux[lvic_pkg::SYM_W-1:0] = system_mode_reg_q;
        if (hit_req)   rd_mux[7:0] = lvl_req;
        if (hit_pend)  rd_mux[NS-1:0] = src_pend_q;
        if (hit_en)    rd_mux[NS-1:0] = src_en_q;
        if (hit_stat)  rd_mux[lvic_pkg::EVT_W-1:0] = evt_stat_q;
        if (hit_emask) rd_mux[lvic_pkg::EVT_W-1:0] = evt_mask_q;
        if (hit_last)  rd_mux[7:0] = last_vec_q;
    end

    // registered read data: taken on the setup cycle, valid in access phase
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

endmodule : lvic_ctl
`default_nettype wire

// ==== testbench/lvic_ctl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module lvic_ctl_monitor (
    input wire logic                         mclk,
    input wire logic                         resetn,
    input wire logic                         global_off_instr,
    input wire logic                         cpu_irq_req,
    input wire logic                         cpu_grant,
    input wire logic                         push_req,
    input wire logic                         push_done,
    input wire logic                         vec_rd_en,
    input wire logic [lvic_pkg::HADDR_W-1:0] vec_rd_addr,
    input wire logic                         handler_valid,
    input wire logic [lvic_pkg::HADDR_W-1:0] reset_vector
);
    // ================
    // dispatch sequence
    // ================
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    grant_push_a: assert property (cpu_irq_req && cpu_grant |=> push_req)
        else $error("push not requested after grant");
    grant_closes_a: assert property (cpu_irq_req && cpu_grant |=> !cpu_irq_req)
        else $error("request still offered after grant");
    idle_only_a: assert property (cpu_irq_req |-> !push_req && !vec_rd_en)
        else $error("request offered while busy");
    fetch_pair_a: assert property (push_req && push_done |=>
        vec_rd_en && !vec_rd_addr[0] ##1 vec_rd_en && vec_rd_addr == $past(vec_rd_addr) + 16'h0001)
        else $error("vector bytes not fetched in order");
    load_time_a: assert property (push_req && push_done |-> ##4 handler_valid)
        else $error("handler address late");
    valid_pulse_a: assert property (handler_valid |=> !handler_valid)
        else $error("handler valid longer than one cycle");
    vec_area_a: assert property (vec_rd_en |-> vec_rd_addr inside {[16'h00d0:16'h00f1]})
        else $error("vector fetch outside vector area");
    reset_addr_a: assert property (reset_vector == 16'h0100)
        else $error("reset vector wrong");
    off_wins_a: assert property (global_off_instr |=> !cpu_irq_req)
        else $error("request after global disable");
    boot_quiet_a: assert property ($rose(resetn) |-> !cpu_irq_req)
        else $error("request right after reset");
endmodule : lvic_ctl_monitor

bind lvic_ctl lvic_ctl_monitor i_lvic_ctl_monitor (.mclk, .resetn, .global_off_instr,
    .cpu_irq_req, .cpu_grant, .push_req, .push_done, .vec_rd_en, .vec_rd_addr,
    .handler_valid, .reset_vector);
`default_nettype wire

// ==== testbench/lvic_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lvic_cpu_model (
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    input  wire logic [1:0]                   push_lag,
    input  wire logic                         cpu_irq_req,
    output logic                              cpu_grant,
    input  wire logic                         push_req,
    output logic                              push_done,
    input  wire logic                         vec_rd_en,
    input  wire logic [lvic_pkg::HADDR_W-1:0] vec_rd_addr,
    output logic      [7:0]                   vec_rd_data
);
    logic [1:0] lag_q;

    always @(posedge mclk) begin
        if (!resetn) begin
            cpu_grant <= 1'b0;
            push_done <= 1'b0;
            lag_q <= 2'h0;
            vec_rd_data <= 8'h00;
        end else begin
            cpu_grant <= cpu_irq_req;
            // stack writes may take a few cycles, so the block must wait
            lag_q <= (push_req && !push_done) ? lag_q + 2'h1 : 2'h0;
            push_done <= push_req && !push_done && lag_q == push_lag;
            // byte pattern differs per address so a wrong fetch shows
            vec_rd_data <= vec_rd_en ? (vec_rd_addr[7:0] ^ 8'ha5) : ~vec_rd_data;
        end
    end
endmodule : lvic_cpu_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, vec_rd_data;
    logic [31:0] pwdata, prdata, rdat;
    logic [16:0] src_event;
    logic [15:0] vec_rd_addr, handler_addr;
    logic [2:0]  cpu_irq_level;
    logic [1:0]  push_lag;
    logic        global_on_instr, global_off_instr, cpu_irq_req, cpu_grant, push_req;
    logic        push_done, vec_rd_en, handler_valid, irq;
    int          checks, mismatches;

    lvic_ctl i_lvic_ctl (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .src_event, .global_on_instr, .global_off_instr, .cpu_irq_req,
        .cpu_irq_level, .cpu_grant, .push_req, .push_done, .vec_rd_en, .vec_rd_addr,
        .vec_rd_data, .handler_addr, .handler_valid, .reset_vector(), .irq);
    lvic_cpu_model i_lvic_cpu_model (.mclk, .resetn, .push_lag, .cpu_irq_req, .cpu_grant,
        .push_req, .push_done, .vec_rd_en, .vec_rd_addr, .vec_rd_data);

    always #2.5 mclk = ~mclk;

    // ================
    // common tasks
    // ================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic expire(input string what);
        mismatches++;
        $display("[FAIL] %s expected done seen timeout", what);
        tally_and_finish();
    endtask : expire

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 16);
        if (n == 16) expire("apb ready");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rdat);
    endtask : rd_chk

    // sources are edge sensitive, so each raise starts from a low line
    task automatic raise(input logic [16:0] src);
        @(posedge mclk);
        src_event <= src;
        repeat (4) @(posedge mclk);
        src_event <= 17'h00000;
        global_on_instr <= 1'b1;
        @(posedge mclk);
        global_on_instr <= 1'b0;
    endtask : raise

    task automatic serve(input logic [16:0] src, input logic [7:0] prio, input logic [7:0] vec);
        int n;
        apb(1'b1, lvic_pkg::OFS_SRC_PEND, 32'h0001ffff);
        apb(1'b1, lvic_pkg::OFS_LEVEL_PRIO, {24'h0, prio});
        raise(src);
        n = 0;
        do begin @(posedge mclk); n++; end while (handler_valid !== 1'b1 && n < 40);
        if (n == 40) expire("handler valid");
        check("handler", {16'h0, vec ^ 8'ha5, (vec | 8'h01) ^ 8'ha5}, {16'h0, handler_addr});
        rd_chk("last vector", lvic_pkg::OFS_LAST_VEC, {24'h0, vec});
        rd_chk("global enable", lvic_pkg::OFS_SYS_MODE, 32'h0);
    endtask : serve

    // ================
    // scenarios
    // ================
    task automatic test_regs();
        rd_chk("level mask", lvic_pkg::OFS_LEVEL_MASK, 32'h0);
        rd_chk("system mode", lvic_pkg::OFS_SYS_MODE, 32'h0);
        rd_chk("source enable", lvic_pkg::OFS_SRC_EN, 32'h0001ffff);
        apb(1'b1, lvic_pkg::OFS_LEVEL_MASK, 32'hffffff5a);
        rd_chk("mask write", lvic_pkg::OFS_LEVEL_MASK, 32'h5a);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'h1, {31'h0, rerr});
        check("unmapped data", 32'h0, rdat);
        $display("test regs done");
    endtask : test_regs

    task automatic test_sources();
        apb(1'b1, lvic_pkg::OFS_LEVEL_MASK, 32'hff);
        for (int i = 0; i < 17; i++) begin
            push_lag <= (i > 8) ? 2'h3 : 2'h0;
            serve(17'h1 << i, 8'h00, 8'hd0 + 8'(2 * i));
            rd_chk("pending", lvic_pkg::OFS_SRC_PEND,
                   lvic_pkg::HW_CLR_MASK[i] ? 32'h0 : (32'h1 << i));
        end
        $display("test sources done");
    endtask : test_sources

    task automatic test_prio();
        serve(17'h00003, 8'h00, 8'hd0);
        serve(17'h10001, 8'h00, 8'hd0);
        serve(17'h10001, 8'h04, 8'hf0);
        serve(17'h00005, 8'h08, 8'hd4);
        serve(17'h00240, 8'h10, 8'hdc);
        serve(17'h00240, 8'h00, 8'he2);
        $display("test prio done");
    endtask : test_prio

    task automatic test_mask();
        apb(1'b1, lvic_pkg::OFS_SRC_PEND, 32'h0001ffff);
        apb(1'b1, lvic_pkg::OFS_EVT_STAT, 32'h3);
        apb(1'b1, lvic_pkg::OFS_EVT_MASK, 32'h1);
        apb(1'b1, lvic_pkg::OFS_LEVEL_MASK, 32'hfe);
        raise(17'h00001);
        repeat (4) @(posedge mclk);
        check("masked request", 32'h0, {31'h0, cpu_irq_req});
        rd_chk("level request", lvic_pkg::OFS_LEVEL_REQ, 32'h1);
        check("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, lvic_pkg::OFS_EVT_MASK, 32'h0);
        @(negedge mclk);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, lvic_pkg::OFS_EVT_MASK, 32'h1);
        apb(1'b1, lvic_pkg::OFS_EVT_STAT, 32'h1);
        @(negedge mclk);
        check("irq cleared", 32'h0, {31'h0, irq});
        @(posedge mclk);
        global_off_instr <= 1'b1;
        @(posedge mclk);
        global_off_instr <= 1'b0;
        apb(1'b1, lvic_pkg::OFS_LEVEL_MASK, 32'hff);
        repeat (3) @(posedge mclk);
        check("disabled request", 32'h0, {31'h0, cpu_irq_req});
        $display("test mask done");
    endtask : test_mask

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite, global_on_instr, global_off_instr} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        src_event = 17'h00000;
        push_lag = 2'h0;
        checks = 0;
        mismatches = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        test_regs();
        test_sources();
        test_prio();
        test_mask();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
